/* File: hpc_converter.sv */
// packed half/single precision converter with avalon register slave
//
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module hpc_converter (
    // clock, reset, enable
    input  wire logic                  CORE_CLK,
    input  wire logic                  RST,
    input  wire logic                  CE,
    // avalon-mm slave
    input  wire logic [hpc_pkg::AW-1:0] AVS_ADDRESS,
    input  wire logic                  AVS_READ,
    input  wire logic                  AVS_WRITE,
    input  wire logic [31:0]           AVS_WRITEDATA,
    input  wire logic [3:0]            AVS_BYTEENABLE,
    output logic      [31:0]           AVS_READDATA,
    output logic                       AVS_WAITREQUEST,
    // pipeline events
    output logic                       OP_DONE,
    output logic                       VEC_FAULT,
    output logic                       UNDEF_FAULT
);

    localparam int L = hpc_pkg::LANES;

    typedef struct packed {
        hpc_pkg::hpc_bus_t            bus;
        logic                         waitreq;
        logic [31:0]                  rdata;
        logic [hpc_pkg::CTRL_W-1:0]   ctrl;
        logic [hpc_pkg::CMD_W-1:0]    cmd;
        logic [31:0]                  src0;
        logic [31:0]                  src1;
        logic [31:0]                  res0;
        logic [31:0]                  res1;
        logic [hpc_pkg::STAT_W-1:0]   stat;
        logic [L-1:0]                 exc_lanes;
        logic                         done;
        logic                         vec;
        logic                         undef;
    } hpc_state_t;

    localparam hpc_state_t ST_RESET = '{
        bus:       hpc_pkg::HPC_BS_IDLE,
        waitreq:   1'h1,
        rdata:     32'h00000000,
        ctrl:      hpc_pkg::CTRL_RESET,
        cmd:       9'h000,
        src0:      32'h00000000,
        src1:      32'h00000000,
        res0:      32'h00000000,
        res1:      32'h00000000,
        stat:      8'h00,
        exc_lanes: 2'h0,
        done:      1'h0,
        vec:       1'h0,
        undef:     1'h0
    };

    hpc_state_t st;
    hpc_state_t next_st;

    // byte lane merge for partial writes
    function automatic logic [31:0] hpc_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i+:8] = wd[8*i+:8];
            end
        end
        return r;
    endfunction

    // single to half narrowing of one lane: {flags, half}
    function automatic logic [20:0] hpc_narrow(
        input logic [31:0] x,
        input logic [1:0]  rnd,
        input logic        flush
    );
        logic                     s;
        logic [7:0]               e;
        logic [22:0]              m;
        logic [23:0]              sig;
        int                       ex;
        logic [5:0]               sh;
        logic [87:0]              v;
        logic [10:0]              kept;
        logic                     g;
        logic                     stk;
        logic                     inc;
        logic                     tiny;
        logic [9:0]               base;
        logic [19:0]              mag;
        logic [hpc_pkg::NFLG-1:0] f;
        logic [15:0]              h;
        s   = x[31];
        e   = x[30:23];
        m   = x[22:0];
        f   = 5'h00;
        h   = 16'h0000;
        sig = {(e != 8'h00), m};
        ex  = (e == 8'h00) ? 1 - hpc_pkg::SGL_BIAS
                           : int'(e) - hpc_pkg::SGL_BIAS;
        tiny = (ex < hpc_pkg::HLF_EMIN);
        if (!tiny) begin
            sh = 6'(hpc_pkg::NRW_SHIFT);
        end else if (ex < hpc_pkg::HLF_EMIN + hpc_pkg::NRW_SHIFT
                          - hpc_pkg::SH_MAX) begin
            sh = 6'(hpc_pkg::SH_MAX);
        end else begin
            sh = 6'(hpc_pkg::NRW_SHIFT + hpc_pkg::HLF_EMIN - ex);
        end
        // wide enough that no source bit falls off the low end
        v    = {sig, 64'h0000000000000000} >> sh;
        kept = v[74:64];
        g    = v[63];
        stk  = |v[62:0];
        unique case (hpc_pkg::hpc_rnd_t'(rnd))
            hpc_pkg::HPC_RND_NEAR:  inc = g & (stk | kept[0]);
            hpc_pkg::HPC_RND_DOWN:  inc = s & (g | stk);
            hpc_pkg::HPC_RND_UP:    inc = !s & (g | stk);
            hpc_pkg::HPC_RND_TRUNC: inc = 1'h0;
        endcase
        // a denormal result carries no exponent; carry reaches min normal
        base = tiny ? 10'h000 : 10'(ex - hpc_pkg::HLF_EMIN);
        mag  = {base, 10'h000} + 20'(kept) + 20'(inc);
        if (e == hpc_pkg::SGL_EXP_ONES) begin
            if (m == 23'h000000) begin
                h = {s, hpc_pkg::HLF_EXP_ONES, 10'h000};
            end else begin
                h = {s, hpc_pkg::HLF_EXP_ONES, m[22:13]};
                if (!m[22]) begin
                    h[9]           = 1'h1;
                    f[hpc_pkg::FLG_INV] = 1'h1;
                end
            end
        end else if (sig == 24'h000000) begin
            h = {s, 15'h0000};
        end else begin
            f[hpc_pkg::FLG_DEN] = (e == 8'h00);
            f[hpc_pkg::FLG_PRC] = g | stk;
            if (mag >= hpc_pkg::HLF_MAG_INF) begin
                f[hpc_pkg::FLG_OVF] = 1'h1;
                f[hpc_pkg::FLG_PRC] = 1'h1;
                h = {s, hpc_pkg::HLF_EXP_ONES, 10'h000};
            end else if (tiny && flush) begin
                f[hpc_pkg::FLG_UNF] = 1'h1;
                f[hpc_pkg::FLG_PRC] = 1'h1;
                h = {s, 15'h0000};
            end else begin
                f[hpc_pkg::FLG_UNF] = tiny;
                h = {s, mag[14:0]};
            end
        end
        return {f, h};
    endfunction

    // command as it will stand after the current write
    logic [31:0]               cmd_merge;
    logic [hpc_pkg::CMD_W-1:0] cmd_wr;
    logic [7:0]                imm;
    logic [1:0]                rnd_sel;
    logic                      flush;
    logic [hpc_pkg::NFLG-1:0]  masks;

    assign cmd_merge = hpc_merge({23'h000000, st.cmd}, AVS_WRITEDATA,
                                 AVS_BYTEENABLE);
    assign cmd_wr  = cmd_merge[hpc_pkg::CMD_W-1:0];
    assign imm     = cmd_wr[7:0];
    assign flush   = st.ctrl[hpc_pkg::CTRL_FLUSH];
    assign masks   = st.ctrl[hpc_pkg::CTRL_MASK_LSB+:hpc_pkg::NFLG];
    // upper immediate bits are never looked at
    assign rnd_sel = imm[hpc_pkg::IMM_SRC_SEL]
                   ? st.ctrl[hpc_pkg::CTRL_RND_LSB+:2]
                   : imm[1:0];

    logic [L-1:0][31:0]               src_sgl;
    logic [L-1:0][15:0]               n_half;
    logic [L-1:0][hpc_pkg::NFLG-1:0]  n_flg;
    logic [L-1:0][31:0]               w_sgl;
    logic [L-1:0]                     w_inv;

    assign src_sgl = {st.src1, st.src0};

    // each lane has its own narrowing and widening path
    for (genvar l = 0; l < L; l++) begin : g_lane
        assign {n_flg[l], n_half[l]} =
            hpc_narrow(src_sgl[l], rnd_sel, flush);
        hpc_widen u_widen (
            .half_in    (st.src0[16*l+:16]),
            .single_out (w_sgl[l]),
            .invalid    (w_inv[l])
        );
    end

    // register read mux
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h00000000;
        unique case (AVS_ADDRESS)
            hpc_pkg::OFS_CTRL: rd_mux = {23'h000000, st.ctrl};
            hpc_pkg::OFS_CMD:  rd_mux = {23'h000000, st.cmd};
            hpc_pkg::OFS_SRC0: rd_mux = st.src0;
            hpc_pkg::OFS_SRC1: rd_mux = st.src1;
            hpc_pkg::OFS_RES0: rd_mux = st.res0;
            hpc_pkg::OFS_RES1: rd_mux = st.res1;
            hpc_pkg::OFS_STAT: rd_mux = {22'h000000, st.exc_lanes, st.stat};
            hpc_pkg::OFS_FEAT: begin
                rd_mux[hpc_pkg::FEAT_HALF] = 1'h1;
                rd_mux[hpc_pkg::FEAT_WIDE] = 1'h1;
            end
            default:           rd_mux = 32'h00000000;
        endcase
    end

    // per-lane flags of the operation being issued
    logic                              op_widen;
    logic [L-1:0][hpc_pkg::NFLG-1:0]   lane_flg;
    logic [L-1:0]                      lane_exc;
    logic [hpc_pkg::NFLG-1:0]          flg_or;
    logic                              exc;
    logic [31:0]                       wmerge;
    logic [hpc_pkg::STAT_W-1:0]        stat_clr;
    logic [hpc_pkg::STAT_W-1:0]        stat_set;
    logic                              do_write;

    always_comb begin
        op_widen = cmd_wr[hpc_pkg::CMD_OP];
        flg_or   = 5'h00;
        for (int l = 0; l < L; l++) begin
            lane_flg[l] = op_widen ? {4'h0, w_inv[l]} : n_flg[l];
            // a masked flag still sets its status bit but raises no exception
            lane_exc[l] = |(lane_flg[l] & ~masks);
            flg_or      = flg_or | lane_flg[l];
        end
        exc = |lane_exc;
    end

    always_comb begin
        next_st      = st;
        next_st.done = 1'h0;
        next_st.vec   = 1'h0;
        next_st.undef = 1'h0;
        do_write     = 1'h0;
        stat_clr     = 8'h00;
        stat_set     = 8'h00;
        wmerge       = 32'h00000000;
        unique case (st.bus)
            hpc_pkg::HPC_BS_IDLE: begin
                if (AVS_READ || AVS_WRITE) begin
                    next_st.bus     = hpc_pkg::HPC_BS_ACK;
                    next_st.waitreq = 1'h0;
                    next_st.rdata   = AVS_READ ? rd_mux : 32'h00000000;
                end
            end
            hpc_pkg::HPC_BS_ACK: begin
                next_st.bus     = hpc_pkg::HPC_BS_IDLE;
                next_st.waitreq = 1'h1;
                do_write        = AVS_WRITE;
            end
        endcase
        if (do_write) begin
            unique case (AVS_ADDRESS)
                hpc_pkg::OFS_CTRL: begin
                    wmerge = hpc_merge({23'h000000, st.ctrl},
                                       AVS_WRITEDATA, AVS_BYTEENABLE);
                    next_st.ctrl = wmerge[hpc_pkg::CTRL_W-1:0];
                end
                hpc_pkg::OFS_SRC0: begin
                    next_st.src0 = hpc_merge(st.src0, AVS_WRITEDATA,
                                             AVS_BYTEENABLE);
                end
                hpc_pkg::OFS_SRC1: begin
                    next_st.src1 = hpc_merge(st.src1, AVS_WRITEDATA,
                                             AVS_BYTEENABLE);
                end
                hpc_pkg::OFS_STAT: begin
                    wmerge   = hpc_merge(32'h00000000, AVS_WRITEDATA,
                                         AVS_BYTEENABLE);
                    stat_clr = wmerge[hpc_pkg::STAT_W-1:0];
                end
                hpc_pkg::OFS_CMD: begin
                    next_st.cmd       = cmd_wr;
                    next_st.done      = 1'h1;
                    next_st.exc_lanes = lane_exc;
                    stat_set[hpc_pkg::NFLG-1:0] = flg_or;
                    stat_set[hpc_pkg::STAT_SUP] = exc;
                    if (exc) begin
                        if (st.ctrl[hpc_pkg::CTRL_OSX]) begin
                            next_st.vec = 1'h1;
                            stat_set[hpc_pkg::STAT_VEC] = 1'h1;
                        end else begin
                            next_st.undef = 1'h1;
                            stat_set[hpc_pkg::STAT_UNDEF] = 1'h1;
                        end
                    end else if (op_widen) begin
                        next_st.res0 = w_sgl[0];
                        next_st.res1 = w_sgl[1];
                    end else begin
                        next_st.res0 = {n_half[1], n_half[0]};
                        next_st.res1 = 32'h00000000;
                    end
                    // no result is written under an unmasked exception
                end
                default: begin
                    wmerge = 32'h00000000;
                end
            endcase
        end
        // a flag set in the same cycle as its clear survives
        next_st.stat = (st.stat & ~stat_clr) | stat_set;
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            st <= ST_RESET;
        end else if (CE) begin
            st <= next_st;
        end
    end

    assign AVS_READDATA    = st.rdata;
    assign AVS_WAITREQUEST = st.waitreq;
    assign OP_DONE         = st.done;
    assign VEC_FAULT       = st.vec;
    assign UNDEF_FAULT     = st.undef;

endmodule // hpc_converter

/* File: hpc_converter_properties.sv */
// concurrent checks on the converter's bus and pipeline event ports
`timescale 1ns/1ps
module hpc_converter_properties (
    // clock, reset, enable
    input wire logic                    CORE_CLK,
    input wire logic                    RST,
    input wire logic                    CE,
    // avalon-mm slave
    input wire logic [hpc_pkg::AW-1:0]  AVS_ADDRESS,
    input wire logic                    AVS_READ,
    input wire logic                    AVS_WRITE,
    input wire logic [31:0]             AVS_WRITEDATA,
    input wire logic [3:0]              AVS_BYTEENABLE,
    input wire logic [31:0]             AVS_READDATA,
    input wire logic                    AVS_WAITREQUEST,
    // pipeline events
    input wire logic                    OP_DONE,
    input wire logic                    VEC_FAULT,
    input wire logic                    UNDEF_FAULT
);
    logic [8:0] ctrl_m;
    wire        acc = !AVS_WAITREQUEST && (AVS_READ || AVS_WRITE);

    // mirror of the control word as written over the bus
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ctrl_m <= hpc_pkg::CTRL_RESET;
        end else if (CE && acc && AVS_WRITE
                     && AVS_ADDRESS == hpc_pkg::OFS_CTRL) begin
            if (AVS_BYTEENABLE[0]) ctrl_m[7:0] <= AVS_WRITEDATA[7:0];
            if (AVS_BYTEENABLE[1]) ctrl_m[8] <= AVS_WRITEDATA[8];
        end
    end

    default clocking @(posedge CORE_CLK); endclocking
    // a frozen block answers nothing, so frozen cycles are not judged
    default disable iff (RST || !CE);

    property p_answer;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |-> ##[0:2] acc;
    endproperty
    a_answer: assert property (p_answer) else $error("no bus answer");

    property p_done_cause;
        OP_DONE |-> $past(acc && AVS_WRITE
                          && AVS_ADDRESS == hpc_pkg::OFS_CMD);
    endproperty
    a_done_cause: assert property (p_done_cause)
        else $error("op done without command");

    property p_vec_os;
        VEC_FAULT |-> ctrl_m[hpc_pkg::CTRL_OSX] && OP_DONE;
    endproperty
    a_vec_os: assert property (p_vec_os)
        else $error("vector fault without os support");

    property p_undef_os;
        UNDEF_FAULT |-> !ctrl_m[hpc_pkg::CTRL_OSX] && OP_DONE;
    endproperty
    a_undef_os: assert property (p_undef_os)
        else $error("undefined opcode fault with os support");

    property p_masked;
        OP_DONE && (&ctrl_m[7:3]) |-> !VEC_FAULT && !UNDEF_FAULT;
    endproperty
    a_masked: assert property (p_masked)
        else $error("fault while all masked");

    property p_pulse;
        VEC_FAULT || UNDEF_FAULT |=> !VEC_FAULT && !UNDEF_FAULT;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("fault longer than one cycle");

    property p_feat;
        acc && AVS_READ && AVS_ADDRESS == hpc_pkg::OFS_FEAT
            |-> AVS_READDATA == 32'h30000000;
    endproperty
    a_feat: assert property (p_feat)
        else $error("feature word wrong");

    property p_ctrl_rb;
        acc && AVS_READ && AVS_ADDRESS == hpc_pkg::OFS_CTRL
            |-> AVS_READDATA == {23'h0, ctrl_m};
    endproperty
    a_ctrl_rb: assert property (p_ctrl_rb)
        else $error("control readback wrong");
endmodule // hpc_converter_properties

bind hpc_converter hpc_converter_properties chk_u (
    .CORE_CLK, .RST, .CE, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
    .OP_DONE, .VEC_FAULT, .UNDEF_FAULT
);

/* File: hpc_converter_tb.sv */
// self-checking bench for the half precision converter
`timescale 1ns/1ps
module hpc_converter_tb;
    localparam logic [8:0] MSK = 9'h1F8;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic [4:0]  address;
    logic        read, write, waitreq, op_done, fault_vec, fault_undef;
    logic [31:0] wdata, rdata;
    logic [3:0]  be;
    logic [31:0] exp_rd[$];
    logic [1:0]  exp_ev[$];
    logic [31:0] rtab[4] = '{32'hBC013C01, 32'hBC013C00,
                             32'hBC003C01, 32'hBC003C00};
    int          n_errors = 0;
    int          total_checks = 0;
    int          cyc = 0;

    always #20 core_clk = ~core_clk;

    hpc_converter dut_u (
        .CORE_CLK(core_clk), .RST(rst), .CE(ce),
        .AVS_ADDRESS(address), .AVS_READ(read), .AVS_WRITE(write),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
        .OP_DONE(op_done), .VEC_FAULT(fault_vec), .UNDEF_FAULT(fault_undef)
    );

    hpc_pipe_model pipe_u (
        .clk(core_clk), .waitreq(waitreq), .rdata(rdata),
        .addr(address), .rd(read), .wr(write), .wdata(wdata), .be(be)
    );

    task automatic finish_test();
        if (n_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s %h not %h",
                     $time, what, got, exp);
        end
    endtask

    // monitor: oldest note is compared when a result appears
    always @(posedge core_clk) begin
        if (!rst && read && waitreq === 1'b0)
            chk(rdata, exp_rd.pop_front(), "read");
        if (!rst && op_done !== 1'b0)
            chk({30'h0, fault_vec, fault_undef},
                {30'h0, exp_ev.pop_front()}, "faults");
        else if (!rst && {fault_vec, fault_undef} !== 2'b00)
            chk({30'h0, fault_vec, fault_undef}, 32'h0, "stray fault");
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        pipe_u.xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        pipe_u.xfer(1'b0, a, 32'h0);
    endtask

    task automatic op(input logic [8:0] ctl, input logic [31:0] s0, s1,
                      input logic [8:0] cmd, input logic [31:0] r0, r1,
                      input logic [9:0] st, input logic [1:0] ev);
        wr(hpc_pkg::OFS_STAT, 32'hFF);
        wr(hpc_pkg::OFS_CTRL, {23'h0, ctl});
        wr(hpc_pkg::OFS_SRC0, s0);
        wr(hpc_pkg::OFS_SRC1, s1);
        exp_ev.push_back(ev);
        pipe_u.issue({23'h0, cmd});
        rd(hpc_pkg::OFS_RES0, r0);
        rd(hpc_pkg::OFS_RES1, r1);
        rd(hpc_pkg::OFS_STAT, {22'h0, st});
    endtask

    function automatic logic [31:0] wf(input logic [15:0] h);
        return {h[15], {3'h0, h[14:10]} + 8'h70, h[9:0], 13'h0};
    endfunction

    initial begin
        logic [31:0] r;
        logic [15:0] h0, h1;
        logic [1:0]  m;
        r = $urandom(32'h71CE);
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rd(hpc_pkg::OFS_CTRL, 32'hF8);
        rd(hpc_pkg::OFS_FEAT, 32'h30000000);
        wr(hpc_pkg::OFS_FEAT, 32'h0);
        rd(hpc_pkg::OFS_FEAT, 32'h30000000);
        rd(5'h02, 32'h0);
        // a request raised while frozen waits for the enable
        fork
            rd(hpc_pkg::OFS_CTRL, 32'hF8);
            begin
                @(posedge core_clk);
                ce <= 1'b0;
                repeat (4) begin
                    @(posedge core_clk);
                    chk({31'h0, waitreq}, 32'h1, "frozen bus");
                end
                ce <= 1'b1;
            end
        join
        for (int i = 0; i < 8; i++) begin
            m = i[1:0];
            op(i < 4 ? MSK | {7'h0, ~m} : MSK | {7'h0, m},
               32'h3F801001, 32'hBF801001,
               i < 4 ? {1'b0, 5'h15, 1'b0, m} : {1'b0, 5'h0A, 1'b1, ~m},
               rtab[m], 32'h0, 10'h010, 2'b00);
        end
        op(MSK, 32'h7FC12345, 32'hFF812345, 9'h0, 32'hFE097E09, 32'h0,
           10'h001, 2'b00);
        op(9'h1F0, 32'h7FC12345, 32'hFF812345, 9'h0, 32'hFE097E09, 32'h0,
           10'h2A1, 2'b10);
        op(9'h0F0, 32'h7FC12345, 32'hFF812345, 9'h0, 32'hFE097E09, 32'h0,
           10'h2C1, 2'b01);
        op(MSK, 32'h3C007D00, 32'h0, 9'h100, 32'h7FE00000, 32'h3F800000,
           10'h001, 2'b00);
        op(MSK, 32'h82000001, 32'h0, 9'h100, 32'h33800000, 32'hB8000000,
           10'h000, 2'b00);
        op(MSK, 32'h1, 32'h0, 9'h0, 32'h0, 32'h0,
           10'h01A, 2'b00);
        op(9'h1B8, 32'h1, 32'h0, 9'h0, 32'h0, 32'h0,
           10'h1BA, 2'b10);
        op(MSK, 32'h33000001, 32'hB87FE000, 9'h0, 32'h84000001, 32'h0,
           10'h018, 2'b00);
        op(MSK | 9'h004, 32'h33000001, 32'hB87FE000, 9'h0, 32'h80000000,
           32'h0, 10'h018, 2'b00);
        op(MSK, 32'h47800000, 32'hC77FE000, 9'h0, 32'hFBFF7C00, 32'h0,
           10'h014, 2'b00);
        op(9'h1D8, 32'h47800000, 32'hC77FE000, 9'h0, 32'hFBFF7C00, 32'h0,
           10'h1B4, 2'b10);
        for (int i = 0; i < 16; i++) begin
            r = $urandom;
            h0 = {r[15], 5'(1 + $urandom_range(29)), r[9:0]};
            h1 = {r[31], 5'(1 + $urandom_range(29)), r[25:16]};
            op(MSK, {h1, h0}, 32'h0, 9'h100, wf(h0), wf(h1),
               10'h000, 2'b00);
            op(MSK, wf(h0), wf(h1), {1'b0, r[23:16]}, {h1, h0}, 32'h0,
               10'h000, 2'b00);
        end
        // every noted result must have been seen
        @(posedge core_clk);
        chk(32'(exp_ev.size() + exp_rd.size()), 32'h0, "missed results");
        finish_test();
    end
endmodule // hpc_converter_tb

/* File: hpc_pipe_model.sv */
// pipeline-side bus master that issues conversion operations
`timescale 1ns/1ps
module hpc_pipe_model (
    // clock and answer
    input  wire logic        clk,
    input  wire logic        waitreq,
    input  wire logic [31:0] rdata,
    // request
    output logic      [4:0]  addr = 5'h1F,
    output logic             rd = 1'b0,
    output logic             wr = 1'b0,
    output logic      [31:0] wdata = 32'h0,
    output logic      [3:0]  be = 4'h0
);
    logic feat_ok = 1'b0;

    task automatic xfer(input logic w, input logic [4:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        rd    <= !w;
        wr    <= w;
        wdata <= d;
        be    <= 4'hF;
        do @(posedge clk); while (waitreq !== 1'b0);
        if (!w && a == hpc_pkg::OFS_FEAT)
            feat_ok <= rdata[29] && rdata[28];
        // released address and data show the inverse, not the last value
        rd    <= 1'b0;
        wr    <= 1'b0;
        addr  <= ~a;
        wdata <= ~d;
        be    <= 4'h0;
    endtask

    // conversions only go out once the feature word was seen
    task automatic issue(input logic [31:0] cmd);
        if (feat_ok) xfer(1'b1, hpc_pkg::OFS_CMD, cmd);
    endtask
endmodule // hpc_pipe_model

/* File: hpc_pkg.sv */
// shared constants and types for the half precision converter
package hpc_pkg;

    // lane count and register address width
    localparam int LANES = 2;
    localparam int AW    = 5;

    // register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_CMD  = 5'h04;
    localparam logic [4:0] OFS_SRC0 = 5'h08;
    localparam logic [4:0] OFS_SRC1 = 5'h0C;
    localparam logic [4:0] OFS_RES0 = 5'h10;
    localparam logic [4:0] OFS_RES1 = 5'h14;
    localparam logic [4:0] OFS_STAT = 5'h18;
    localparam logic [4:0] OFS_FEAT = 5'h1C;

    // control register fields
    localparam int CTRL_RND_LSB  = 0;
    localparam int CTRL_FLUSH    = 2;
    localparam int CTRL_MASK_LSB = 3;
    localparam int CTRL_OSX      = 8;
    localparam int CTRL_W        = 9;
    localparam logic [8:0] CTRL_RESET = 9'h0F8;

    // command register fields
    localparam int CMD_OP      = 8;
    localparam int CMD_W       = 9;
    localparam int IMM_SRC_SEL = 2;

    // flag and status positions
    localparam int NFLG     = 5;
    localparam int FLG_INV  = 0;
    localparam int FLG_DEN  = 1;
    localparam int FLG_OVF  = 2;
    localparam int FLG_UNF  = 3;
    localparam int FLG_PRC  = 4;
    localparam int STAT_VEC   = 5;
    localparam int STAT_UNDEF = 6;
    localparam int STAT_SUP = 7;
    localparam int STAT_W   = 8;

    // feature word bits
    localparam int FEAT_HALF = 29;
    localparam int FEAT_WIDE = 28;

    // number formats
    localparam int SGL_BIAS  = 127;
    localparam int HLF_BIAS  = 15;
    localparam int HLF_FRAC  = 10;
    localparam int HLF_EMIN  = -14;
    localparam int NRW_SHIFT = 13;
    localparam int SH_MAX    = 37;
    localparam logic [7:0]  SGL_EXP_ONES = 8'hFF;
    localparam logic [4:0]  HLF_EXP_ONES = 5'h1F;
    localparam logic [19:0] HLF_MAG_INF  = 20'h07C00;

    typedef enum logic [1:0] {
        HPC_RND_NEAR, HPC_RND_DOWN, HPC_RND_UP, HPC_RND_TRUNC
    } hpc_rnd_t;

    typedef enum logic {HPC_BS_IDLE, HPC_BS_ACK} hpc_bus_t;

endpackage

/* File: hpc_widen.sv */
// one lane of half to single precision widening
`timescale 1ns/1ps
module hpc_widen (
    // lane operand
    input  wire logic [15:0] half_in,
    // lane result
    output logic      [31:0] single_out,
    output logic             invalid
);

    logic       s;
    logic [4:0] e;
    logic [9:0] f;
    logic [3:0] p;
    logic [9:0] fn;

    always_comb begin
        s = half_in[15];
        e = half_in[14:10];
        f = half_in[9:0];
        p = 4'h0;
        for (int i = 0; i < hpc_pkg::HLF_FRAC; i++) begin
            if (f[i]) begin
                p = 4'(i);
            end
        end
        fn = 10'(f << (4'hA - p));
        invalid = 1'h0;
        if (e == hpc_pkg::HLF_EXP_ONES) begin
            single_out = {s, hpc_pkg::SGL_EXP_ONES, f, 13'h0000};
            if (f != 10'h000 && !f[9]) begin
                // signaling nan is quieted and reported
                single_out[22] = 1'h1;
                invalid = 1'h1;
            end
        end else if (e == 5'h00 && f == 10'h000) begin
            single_out = {s, 31'h00000000};
        end else if (e == 5'h00) begin
            // denormal source widens exactly, denormal flag untouched
            single_out = {s,
                8'(int'(p) + 1 - hpc_pkg::HLF_BIAS - hpc_pkg::HLF_FRAC
                   + hpc_pkg::SGL_BIAS),
                fn, 13'h0000};
        end else begin
            single_out = {s,
                8'(int'(e) + hpc_pkg::SGL_BIAS - hpc_pkg::HLF_BIAS),
                f, 13'h0000};
        end
    end

endmodule // hpc_widen
